//--- design/afc_chain.sv
// Purpose: filter and decimation chain with operating-mode control
// Assumes: converter samples arrive with a valid pulse after each strobe
// Notes: one output stream; sigma-delta results take the FIFO when that path runs
`timescale 1ns/10ps
`default_nettype none
module afc_chain import afc_pkg::*; (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata_q,
   output logic sd_conv_strobe_q,
   output logic sar_conv_strobe_q,
   input wire logic sd_valid,
   input wire logic [SAMPLE_W-1:0] sd_data,
   input wire logic sar_valid,
   input wire logic [SAMPLE_W-1:0] sar_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [SAMPLE_W-1:0] out_data
);
   logic [7:0] operating_mode_code_q;
   logic [7:0] digital_enable_register_q;
   logic [7:0] trig_q;
   logic [7:0] filter_q;
   logic [7:0] trig_act_q;
   logic [7:0] filter_act_q;
   logic overrun_q;
   logic [15:0] sd_acc_q;
   logic [15:0] sar_acc_q;
   logic [15:0] sd_rate;
   logic [3:0] mode_code;
   logic standby;
   logic sd_on;
   logic sar_on;
   logic hp_on;
   logic comb16;
   logic half_skip;
   logic sinc_v;
   logic [ACC_W-1:0] sinc_d;
   logic signed [ACC_W-1:0] dcf_x1_q;
   logic signed [ACC_W-1:0] dcf_x2_q;
   logic signed [ACC_W+3:0] dcf_sum;
   logic dcf_v_q;
   logic signed [ACC_W-1:0] dcf_d_q;
   logic half_phase_q;
   logic signed [ACC_W-1:0] half_prev_q;
   logic signed [ACC_W:0] half_sum;
   logic dec_v_q;
   logic signed [ACC_W-1:0] dec_d_q;
   logic signed [ACC_W-1:0] post_y_q;
   logic signed [ACC_W-1:0] eq_prev_q;
   logic signed [ACC_W:0] eq_diff;
   logic post_v_q;
   logic signed [ACC_W-1:0] post_d_q;
   logic signed [ACC_W-1:0] sd_hp_s_q;
   logic signed [ACC_W-1:0] sar_hp_s_q;
   logic signed [ACC_W-1:0] sd_hp_s;
   logic signed [ACC_W-1:0] sar_hp_s;
   logic signed [ACC_W-1:0] sar_x;
   logic [2:0] hp_corner;
   logic hp_sd_en;
   logic hp_sar_en;
   logic [1:0] lpf_code;
   logic first_order_iir_on;
   logic eq_on;
   logic res_v_q;
   logic [SAMPLE_W-1:0] res_d_q;
   logic new_v;
   logic [SAMPLE_W-1:0] new_d;
   logic fifo_in_ready;
   logic status_rd;

   // mode decode; every one of the sixteen codes is accepted as written
   assign mode_code = operating_mode_code_q[3:0];
   assign standby = (mode_code == MODE_STANDBY);
   assign sd_on = mode_code[3] | mode_code[2];
   assign sar_on = |mode_code[1:0];
   assign hp_on = (mode_code[3:2] == MODE_HIGH_PERF[3:2]);
   // hardware never steps through standby on its own

   // live register copies steer the chain from the next sinc output, or next SAR sample while the sigma-delta path is off, or at once in standby
   assign comb16 = trig_act_q[TRIG_COMB16_BIT];
   assign half_skip = trig_act_q[TRIG_HALF_SKIP_BIT] | comb16;
   assign hp_corner = filter_act_q[FLT_HP_CORNER_LSB +: 3];
   assign hp_sd_en = (hp_corner != 3'h0) && filter_act_q[FLT_HP_CHAIN_BIT];
   assign hp_sar_en = (hp_corner != 3'h0) && !filter_act_q[FLT_HP_CHAIN_BIT];
   assign lpf_code = filter_act_q[FLT_LPF_LSB +: 2];
   assign first_order_iir_on = trig_act_q[TRIG_FIRST_ORDER_IIR_BIT] && sd_on;
   assign eq_on = hp_on && !filter_act_q[FLT_EQ_SKIP_BIT];
   assign status_rd = reg_rd_en && (reg_addr == ADDR_STATUS);

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         operating_mode_code_q <= OPERATING_MODE_CODE_RST;
         digital_enable_register_q <= DIGITAL_ENABLE_REGISTER_RST;
         trig_q <= TRIG_RST;
         filter_q <= FILTER_RST;
      end else if (reg_wr_en) begin
         case (reg_addr)
            ADDR_OPERATING_MODE_CODE: operating_mode_code_q <= reg_wdata;
            ADDR_DIGITAL_ENABLE_REGISTER: digital_enable_register_q <= reg_wdata;
            ADDR_TRIG: trig_q <= reg_wdata;
            ADDR_FILTER: filter_q <= reg_wdata;
            default: ;
         endcase
      end
   end

   // shadows follow freely in standby so the first sample sees the setup
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         trig_act_q <= TRIG_RST;
         filter_act_q <= FILTER_RST;
      end else if (standby || sinc_v || (sar_valid && !sd_on)) begin
         trig_act_q <= trig_q;
         filter_act_q <= filter_q;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         reg_rdata_q <= 8'h00;
      end else if (reg_rd_en) begin
         case (reg_addr)
            ADDR_OPERATING_MODE_CODE: reg_rdata_q <= operating_mode_code_q;
            ADDR_DIGITAL_ENABLE_REGISTER: reg_rdata_q <= digital_enable_register_q;
            ADDR_TRIG: reg_rdata_q <= trig_q;
            ADDR_FILTER: reg_rdata_q <= filter_q;
            ADDR_STATUS: reg_rdata_q <= {3'h0, standby, !fifo_in_ready, sar_on, sd_on, overrun_q};
            default: reg_rdata_q <= 8'h00;
         endcase
      end
   end

   // fractional divider: average strobe rate is exact though 40 MHz is no multiple
   assign sd_rate = digital_enable_register_q[DIG_CLK_DBL_BIT] ? 16'(SD_RATE2_KHZ) : 16'(SD_RATE_KHZ);

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         sd_acc_q <= 16'h0000;
         sd_conv_strobe_q <= 1'b0;
      end else if (!sd_on) begin
         sd_acc_q <= 16'h0000;
         sd_conv_strobe_q <= 1'b0;
      end else if (sd_acc_q + sd_rate >= 16'(CLK_KHZ)) begin
         sd_acc_q <= sd_acc_q + sd_rate - 16'(CLK_KHZ);
         sd_conv_strobe_q <= 1'b1;
      end else begin
         sd_acc_q <= sd_acc_q + sd_rate;
         sd_conv_strobe_q <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         sar_acc_q <= 16'h0000;
         sar_conv_strobe_q <= 1'b0;
      end else if (!sar_on) begin
         sar_acc_q <= 16'h0000;
         sar_conv_strobe_q <= 1'b0;
      end else if (sar_acc_q + 16'(SAR_RATE_KHZ) >= 16'(CLK_KHZ)) begin
         sar_acc_q <= sar_acc_q + 16'(SAR_RATE_KHZ) - 16'(CLK_KHZ);
         sar_conv_strobe_q <= 1'b1;
      end else begin
         sar_acc_q <= sar_acc_q + 16'(SAR_RATE_KHZ);
         sar_conv_strobe_q <= 1'b0;
      end
   end

   afc_sinc3 u_sinc (
      .core_clk(core_clk),
      .rst(rst),
      .flush(standby),
      .in_valid(sd_valid && sd_on),
      .in_data(sd_data),
      .dec16(comb16),
      .out_valid(sinc_v),
      .out_data(sinc_d)
   );

   // droop FIR (-1, 10, -1)/8 has unity DC gain and lifts the sinc roll-off
   assign dcf_sum = 28'(-$signed(sinc_d)) + 28'(dcf_x1_q) * 28'sd10 - 28'(dcf_x2_q);

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         dcf_x1_q <= '0;
         dcf_x2_q <= '0;
         dcf_v_q <= 1'b0;
         dcf_d_q <= '0;
      end else if (standby) begin
         dcf_x1_q <= '0;
         dcf_x2_q <= '0;
         dcf_v_q <= 1'b0;
         dcf_d_q <= '0;
      end else begin
         dcf_v_q <= sinc_v;
         if (sinc_v) begin
            dcf_x1_q <= sinc_d;
            dcf_x2_q <= dcf_x1_q;
            dcf_d_q <= filter_act_q[FLT_DROOP_SKIP_BIT] ? sinc_d
                       : ACC_W'(dcf_sum >>> 3);
         end
      end
   end

   // half-rate stage: averages each pair, emits on the second of two
   assign half_sum = {half_prev_q[ACC_W-1], half_prev_q} + {dcf_d_q[ACC_W-1], dcf_d_q};

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         half_phase_q <= 1'b0;
         half_prev_q <= '0;
         dec_v_q <= 1'b0;
         dec_d_q <= '0;
      end else if (standby) begin
         half_phase_q <= 1'b0;
         half_prev_q <= '0;
         dec_v_q <= 1'b0;
         dec_d_q <= '0;
      end else if (half_skip) begin
         half_phase_q <= 1'b0;
         dec_v_q <= dcf_v_q;
         if (dcf_v_q) begin
            dec_d_q <= dcf_d_q;
         end
      end else begin
         dec_v_q <= dcf_v_q && half_phase_q;
         if (dcf_v_q) begin
            half_phase_q <= !half_phase_q;
            half_prev_q <= dcf_d_q;
            if (half_phase_q) begin
               dec_d_q <= ACC_W'(half_sum >>> 1);
            end
         end
      end
   end

   // equalizer, first-order IIR and low-pass are exclusive; IIR wins if misused
   assign eq_diff = {dec_d_q[ACC_W-1], dec_d_q} - {eq_prev_q[ACC_W-1], eq_prev_q};

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         post_y_q <= '0;
         eq_prev_q <= '0;
         post_v_q <= 1'b0;
         post_d_q <= '0;
      end else if (standby) begin
         post_y_q <= '0;
         eq_prev_q <= '0;
         post_v_q <= 1'b0;
         post_d_q <= '0;
      end else begin
         post_v_q <= dec_v_q;
         if (dec_v_q) begin
            eq_prev_q <= dec_d_q;
            if (first_order_iir_on) begin
               post_y_q <= afc_step(post_y_q, dec_d_q, FIRST_ORDER_IIR_SHIFT);
               post_d_q <= afc_step(post_y_q, dec_d_q, FIRST_ORDER_IIR_SHIFT);
            end else if (lpf_code != 2'b00) begin
               post_y_q <= afc_step(post_y_q, dec_d_q, {3'h0, lpf_code} + 5'h01);
               post_d_q <= afc_step(post_y_q, dec_d_q, {3'h0, lpf_code} + 5'h01);
            end else if (eq_on) begin
               post_y_q <= dec_d_q;
               post_d_q <= dec_d_q + ACC_W'(eq_diff >>> 2);
            end else begin
               post_y_q <= dec_d_q;
               post_d_q <= dec_d_q;
            end
         end
      end
   end

   // high-pass after decimation so its corner tracks the output rate
   assign sd_hp_s = afc_step(sd_hp_s_q, post_d_q, afc_hp_shift(hp_corner));
   assign sar_x = {sar_data, {FRAC_W{1'b0}}};
   assign sar_hp_s = afc_step(sar_hp_s_q, sar_x, afc_hp_shift(hp_corner));

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         sd_hp_s_q <= '0;
         sar_hp_s_q <= '0;
      end else if (standby) begin
         sd_hp_s_q <= '0;
         sar_hp_s_q <= '0;
      end else begin
         if (post_v_q && hp_sd_en) begin
            sd_hp_s_q <= sd_hp_s;
         end
         if (sar_valid && sar_on && hp_sar_en) begin
            sar_hp_s_q <= sar_hp_s;
         end
      end
   end

   // sigma-delta results own the output; SAR results go out only when the sigma-delta path is off
   always_comb begin
      new_v = 1'b0;
      new_d = '0;
      if (sd_on) begin
         new_v = post_v_q;
         new_d = afc_round(hp_sd_en ? post_d_q - sd_hp_s : post_d_q,
                           digital_enable_register_q[DIG_ROUND_BIT]);
      end else if (sar_on) begin
         new_v = sar_valid;
         new_d = afc_round(hp_sar_en ? sar_x - sar_hp_s : sar_x,
                           digital_enable_register_q[DIG_ROUND_BIT]);
      end
   end

   // result holds while the FIFO is full; a sample arriving then is dropped
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         res_v_q <= 1'b0;
         res_d_q <= '0;
      end else if (standby) begin
         res_v_q <= 1'b0;
      end else if (new_v && (!res_v_q || fifo_in_ready)) begin
         res_v_q <= 1'b1;
         res_d_q <= new_d;
      end else if (fifo_in_ready) begin
         res_v_q <= 1'b0;
      end
   end

   // a drop in the same cycle as the clearing read still sets the flag
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         overrun_q <= 1'b0;
      end else if (new_v && res_v_q && !fifo_in_ready) begin
         overrun_q <= 1'b1;
      end else if (status_rd) begin
         overrun_q <= 1'b0;
      end
   end

   afc_fifo #(
      .WIDTH(SAMPLE_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .core_clk(core_clk),
      .rst(rst),
      .flush(standby),
      .in_valid(res_v_q),
      .in_ready(fifo_in_ready),
      .in_data(res_d_q),
      .out_valid(out_valid),
      .out_ready(out_ready),
      .out_data(out_data)
   );
endmodule
`default_nettype wire

//--- design/afc_fifo.sv
// Purpose: small sample FIFO between the filter chain and its reader
// Assumes: single clock, flush empties it in one cycle
// Notes: out_valid is registered; out_data is read from the head slot
`timescale 1ns/10ps
`default_nettype none
module afc_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic flush,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_ptr_q;
   logic [AW-1:0] rd_ptr_q;
   logic [AW:0] count_q;
   logic [AW:0] count_d;
   logic push;
   logic pop;

   assign in_ready = (count_q != (AW+1)'(DEPTH));
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem_q[rd_ptr_q];

   always_comb begin
      count_d = count_q;
      if (flush) begin
         count_d = '0;
      end else if (push && !pop) begin
         count_d = count_q + 1'b1;
      end else if (pop && !push) begin
         count_d = count_q - 1'b1;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         count_q <= '0;
         out_valid <= 1'b0;
      end else begin
         count_q <= count_d;
         out_valid <= (count_d != '0);
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
      end else if (flush) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
      end else begin
         if (push) begin
            wr_ptr_q <= (wr_ptr_q == AW'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
         end
         if (pop) begin
            rd_ptr_q <= (rd_ptr_q == AW'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (push) begin
         mem_q[wr_ptr_q] <= in_data;
      end
   end
endmodule
`default_nettype wire

//--- design/afc_pkg.sv
// Purpose: shared constants for the accelerometer filter chain and mode control
// Assumes: 8-bit configuration registers, 40 MHz core clock
// Notes: internal samples carry 16 integer and 8 fraction bits
package afc_pkg;
   localparam int SAMPLE_W = 16;
   localparam int ACC_W = 24;
   localparam int FRAC_W = 8;
   localparam int FIFO_DEPTH = 8;

   localparam logic [7:0] ADDR_OPERATING_MODE_CODE = 8'h26;
   localparam logic [7:0] ADDR_DIGITAL_ENABLE_REGISTER = 8'h27;
   localparam logic [7:0] ADDR_TRIG = 8'h49;
   localparam logic [7:0] ADDR_FILTER = 8'h50;
   localparam logic [7:0] ADDR_STATUS = 8'h51;

   localparam logic [7:0] OPERATING_MODE_CODE_RST = 8'h00;
   localparam logic [7:0] DIGITAL_ENABLE_REGISTER_RST = 8'h00;
   localparam logic [7:0] TRIG_RST = 8'h00;
   localparam logic [7:0] FILTER_RST = 8'h00;

   localparam int DIG_CLK_DBL_BIT = 2;
   localparam int DIG_ROUND_BIT = 3;
   localparam int TRIG_HALF_SKIP_BIT = 7;
   localparam int TRIG_COMB16_BIT = 6;
   localparam int TRIG_FIRST_ORDER_IIR_BIT = 5;
   localparam int FLT_DROOP_SKIP_BIT = 7;
   localparam int FLT_EQ_SKIP_BIT = 6;
   localparam int FLT_LPF_LSB = 4;
   localparam int FLT_HP_CHAIN_BIT = 3;
   localparam int FLT_HP_CORNER_LSB = 0;

   localparam logic [3:0] MODE_STANDBY = 4'h0;
   localparam logic [3:0] MODE_HEART_SOUND = 4'h1;
   localparam logic [3:0] MODE_ULTRA_LOW_POWER = 4'h2;
   localparam logic [3:0] MODE_VERY_LOW_POWER = 4'h3;
   localparam logic [3:0] MODE_LOW_POWER = 4'h4;
   localparam logic [3:0] MODE_REDUCED_BW = 4'h8;
   localparam logic [3:0] MODE_HIGH_PERF = 4'hc;

   localparam int CLK_KHZ = 40000;
   localparam int SAR_RATE_KHZ = 256;
   localparam int SD_RATE_KHZ = 512;
   localparam int SD_RATE2_KHZ = 1024;
   localparam logic [4:0] FIRST_ORDER_IIR_SHIFT = 5'h01;

   // first-order step toward x with coefficient 2^-sh
   function automatic logic signed [ACC_W-1:0] afc_step(input logic signed [ACC_W-1:0] y,
                                                        input logic signed [ACC_W-1:0] x,
                                                        input logic [4:0] sh);
      logic signed [ACC_W:0] diff;
      diff = {x[ACC_W-1], x} - {y[ACC_W-1], y};
      return y + ACC_W'(diff >>> sh);
   endfunction

   // corner code to step shift; codes 2 to 6 each lower the corner about four times, 7 equals 6
   function automatic logic [4:0] afc_hp_shift(input logic [2:0] corner);
      case (corner)
         3'h1: return 5'h06;
         3'h2: return 5'h08;
         3'h3: return 5'h0a;
         3'h4: return 5'h0c;
         3'h5: return 5'h0e;
         default: return 5'h10;
      endcase
   endfunction

   // truncation to 16 bits with optional increment of negative results
   function automatic logic [SAMPLE_W-1:0] afc_round(input logic signed [ACC_W-1:0] x,
                                                     input logic neg_up);
      logic [SAMPLE_W-1:0] t;
      t = x[ACC_W-1:FRAC_W];
      if (neg_up && x[ACC_W-1]) begin
         t = t + 16'h0001;
      end
      return t;
   endfunction
endpackage

//--- design/afc_sinc3.sv
// Purpose: third-order comb-integrator decimator, 32x or 16x
// Assumes: one input sample per in_valid pulse
// Notes: modular 32-bit arithmetic, so integrator wrap is harmless
`timescale 1ns/10ps
`default_nettype none
module afc_sinc3 import afc_pkg::*; (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic flush,
   input wire logic in_valid,
   input wire logic [SAMPLE_W-1:0] in_data,
   input wire logic dec16,
   output logic out_valid,
   output logic [ACC_W-1:0] out_data
);
   logic [31:0] int1_q;
   logic [31:0] int2_q;
   logic [31:0] int3_q;
   logic [31:0] dly1_q;
   logic [31:0] dly2_q;
   logic [31:0] dly3_q;
   logic [4:0] phase_q;
   logic [31:0] comb1;
   logic [31:0] comb2;
   logic [31:0] comb3;
   logic last;

   assign last = in_valid && (phase_q == (dec16 ? 5'h0f : 5'h1f));
   assign comb1 = int3_q - dly1_q;
   assign comb2 = comb1 - dly2_q;
   assign comb3 = comb2 - dly3_q;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         int1_q <= '0;
         int2_q <= '0;
         int3_q <= '0;
         phase_q <= '0;
      end else if (flush) begin
         int1_q <= '0;
         int2_q <= '0;
         int3_q <= '0;
         phase_q <= '0;
      end else if (in_valid) begin
         int1_q <= int1_q + {{16{in_data[SAMPLE_W-1]}}, in_data};
         int2_q <= int2_q + int1_q;
         int3_q <= int3_q + int2_q;
         phase_q <= last ? 5'h00 : phase_q + 5'h01;
      end
   end

   // gain is 2^15 at 32x and 2^12 at 16x; shift back to 16.8 format
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         dly1_q <= '0;
         dly2_q <= '0;
         dly3_q <= '0;
         out_valid <= 1'b0;
         out_data <= '0;
      end else if (flush) begin
         dly1_q <= '0;
         dly2_q <= '0;
         dly3_q <= '0;
         out_valid <= 1'b0;
      end else begin
         out_valid <= last;
         if (last) begin
            dly1_q <= int3_q;
            dly2_q <= comb1;
            dly3_q <= comb2;
            out_data <= dec16 ? comb3[27:4] : comb3[30:7];
         end
      end
   end
endmodule
`default_nettype wire

//--- dv/afc_adc_model.sv
// Purpose: converter answering each sample strobe
// Assumes: strobes farther apart than lat
// Notes: outside valid the data toggles, so stale data matches level only on alternate cycles
`timescale 1ns/10ps
`default_nettype none
module afc_adc_model (
   input wire logic core_clk,
   input wire logic strobe,
   input wire logic [3:0] lat,
   input wire logic [15:0] level,
   output logic valid = 1'b0,
   output logic [15:0] data = 16'h0000
);
   int cnt = 0;
   always @(posedge core_clk) begin
      valid <= (cnt == 1);
      data <= (cnt == 1) ? level : ~data;
      cnt <= strobe ? int'(lat) : (cnt > 0 ? cnt - 1 : 0);
   end
endmodule
`default_nettype wire

//--- dv/afc_chk.sv
// Purpose: port checks for afc_chain
// Assumes: register writes land at the taking edge
// Notes: keeps shadow copies of the four control registers
`timescale 1ns/10ps
`default_nettype none
module afc_chk import afc_pkg::*; (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata_q,
   input wire logic sd_conv_strobe_q,
   input wire logic sar_conv_strobe_q,
   input wire logic out_valid,
   input wire logic out_ready,
   input wire logic [SAMPLE_W-1:0] out_data
);
   logic [7:0] sh_q [4];
   logic [1:0] ix;
   logic map;
   logic [3:0] md;
   // 0x26,0x27,0x49,0x50 fold onto 0..3
   assign ix = {reg_addr[6], reg_addr[6] ? reg_addr[4] : reg_addr[0]};
   assign map = reg_addr inside {ADDR_OPERATING_MODE_CODE, ADDR_DIGITAL_ENABLE_REGISTER, ADDR_TRIG, ADDR_FILTER};
   assign md = sh_q[0][3:0];
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         sh_q <= '{default: 8'h00};
      end else if (reg_wr_en && map) begin
         sh_q[ix] <= reg_wdata;
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   property p_hold; !$past(reg_rd_en) |-> $stable(reg_rdata_q); endproperty
   a_hold: assert property (p_hold) else $error("read data moved");
   property p_rmap; reg_rd_en && !reg_wr_en && map |=> reg_rdata_q == sh_q[$past(ix)]; endproperty
   a_rmap: assert property (p_rmap) else $error("readback");
   property p_unmap; reg_rd_en && !map && reg_addr != ADDR_STATUS |=> reg_rdata_q == 8'h00;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read");
   property p_stat; reg_rd_en && !reg_wr_en && reg_addr == ADDR_STATUS |=>
      {reg_rdata_q[4], reg_rdata_q[2:1]} == {md == 4'h0, md[1:0] != 2'h0, md[3] | md[2]};
   endproperty
   a_stat: assert property (p_stat) else $error("status mode bits");
   property p_sdp; sd_conv_strobe_q |=> !sd_conv_strobe_q; endproperty
   a_sdp: assert property (p_sdp) else $error("sd strobe");
   property p_sarp; sar_conv_strobe_q |=> !sar_conv_strobe_q; endproperty
   a_sarp: assert property (p_sarp) else $error("sar strobe");
   property p_head; out_valid && !out_ready && md != 4'h0 && !(reg_wr_en && !reg_addr[6]) |=>
      out_valid && $stable(out_data); endproperty
   a_head: assert property (p_head) else $error("head word moved");
   property p_flush; (md == 4'h0) [*4] |-> !out_valid; endproperty
   a_flush: assert property (p_flush) else $error("standby not flushed");
endmodule
bind afc_chain afc_chk i_chk (.core_clk, .rst, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata,
   .reg_rdata_q, .sd_conv_strobe_q, .sar_conv_strobe_q, .out_valid, .out_ready, .out_data);
`default_nettype wire

//--- dv/tb_top.sv
// Purpose: self-checking bench for afc_chain
// Assumes: a steady input leaves the chain with unity gain
// Notes: fast configs keep the run short
`timescale 1ns/10ps
`default_nettype none
module tb_top import afc_pkg::*;;
   logic core_clk = 1'b0, rst = 1'b1, reg_wr_en = 1'b0, reg_rd_en = 1'b0, out_ready = 1'b1;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata_q;
   logic sd_conv_strobe_q, sar_conv_strobe_q, sd_valid, sar_valid, out_valid;
   logic [15:0] sd_data, sar_data, out_data, w;
   int err_count = 0, n_checks = 0, k, c, e;
   logic [7:0] ra [4] = '{ADDR_OPERATING_MODE_CODE, ADDR_DIGITAL_ENABLE_REGISTER, ADDR_TRIG, ADDR_FILTER};
   logic [7:0] r_tr [5] = '{8'h00, 8'h80, 8'h40, 8'hc0, 8'h40};
   int r_k [5] = '{64, 32, 16, 16, 16};
   logic [7:0] v_md [8] = '{8'h0c, 8'h0c, 8'h08, 8'h04, 8'h0e, 8'h01, 8'h02, 8'h03};
   afc_chain i_dut (.core_clk, .rst, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata_q,
      .sd_conv_strobe_q, .sar_conv_strobe_q, .sd_valid, .sd_data, .sar_valid, .sar_data,
      .out_valid, .out_ready, .out_data);
   afc_adc_model i_sd (.core_clk, .strobe(sd_conv_strobe_q), .lat(4'h2), .level(16'hff9c),
      .valid(sd_valid), .data(sd_data));
   afc_adc_model i_sar (.core_clk, .strobe(sar_conv_strobe_q), .lat(4'hc), .level(16'h0123),
      .valid(sar_valid), .data(sar_data));
   initial forever #12.5 core_clk = ~core_clk;
   task automatic chk(input string n, input logic [15:0] ex, input logic [15:0] g);
      n_checks++;
      if (g !== ex) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", n, ex, g);
      end
   endtask
   task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      #1;
      reg_addr = a;
      reg_wdata = d;
      reg_wr_en = wr;
      reg_rd_en = !wr;
      @(posedge core_clk);
      #1;
      reg_wr_en = 1'b0;
      reg_rd_en = 1'b0;
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] ex);
      acc(1'b0, a, 8'h00);
      chk("register", {8'h00, ex}, {8'h00, reg_rdata_q});
   endtask
   // configure only from standby, then enter the mode
   task automatic cfg(input logic [7:0] m, tr, dg, fl);
      acc(1'b1, ADDR_OPERATING_MODE_CODE, 8'h00);
      acc(1'b1, ADDR_TRIG, tr);
      acc(1'b1, ADDR_DIGITAL_ENABLE_REGISTER, dg);
      acc(1'b1, ADDR_FILTER, fl);
      acc(1'b1, ADDR_OPERATING_MODE_CODE, m);
   endtask
   // pops n words; k and c give inputs and cycles between the last two
   task automatic pw(input int n);
      int t;
      t = 0;
      repeat (n) begin
         k = 0;
         c = 0;
         do begin
            @(negedge core_clk);
            k += int'(sd_valid);
            c++;
            t++;
         end while (!(out_valid === 1'b1 && out_ready) && t < 30000);
         w = out_data;
         @(posedge core_clk);
         #1;
      end
      if (t >= 30000) chk("word wait", 16'h0, 16'h1);
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge core_clk);
      #1;
      rst = 1'b0;
      for (int i = 0; i < 4; i++) rc(ra[i], 8'h00);
      acc(1'b1, ADDR_STATUS, 8'hff);
      rc(ADDR_STATUS, 8'h10);
      rc(8'h33, 8'h00);
      $display("reset test done");
      for (int i = 0; i < 5; i++) begin
         cfg(8'h0c, r_tr[i], {5'h00, i == 4, 2'h0}, 8'h00);
         pw(3);
         chk("inputs per word", 16'(r_k[i]), 16'(k));
         e = r_k[i] * CLK_KHZ / (i == 4 ? SD_RATE2_KHZ : SD_RATE_KHZ);
         chk("cycles per word", 16'h1, 16'(c >= e - 1 && c <= e + 1));
      end
      $display("rate test done");
      for (int i = 0; i < 8; i++) begin
         cfg(v_md[i], 8'hc0, i == 0 ? 8'h04 : 8'h0c, 8'h80);
         pw(6);
         e = i > 4 ? 16'h0123 : (i == 0 ? 16'hff9c : 16'hff9d);
         chk("word", 16'(e), w);
      end
      $display("mode test done");
      // a steady input must come out lowered once the high-pass runs
      cfg(8'h01, 8'h00, 8'h08, 8'h01);
      pw(6);
      chk("high-pass below input", 16'h1, 16'(w < 16'h0123));
      // a step through a lowpass still lags after six words
      cfg(8'h0c, 8'hc0, 8'h0c, 8'hd0);
      pw(6);
      chk("lowpass lag", 16'h1, 16'(w !== 16'hff9d));
      cfg(8'h0c, 8'he0, 8'h0c, 8'hc0);
      pw(6);
      chk("iir lag", 16'h1, 16'(w !== 16'hff9d));
      pw(14);
      chk("iir settled", 16'hff9d, w);
      $display("post filter test done");
      cfg(8'h0c, 8'hc0, 8'h04, 8'h80);
      out_ready = 1'b0;
      repeat (8000) @(posedge core_clk);
      #1;
      rc(ADDR_STATUS, 8'h0b);
      rc(ADDR_STATUS, 8'h0a);
      acc(1'b1, ADDR_OPERATING_MODE_CODE, 8'h00);
      repeat (4) @(posedge core_clk);
      #1;
      chk("valid after flush", 16'h0, {15'h0, out_valid});
      rc(ADDR_STATUS, 8'h10);
      $display("fifo test done");
      stop_test();
   end
   initial begin
      repeat (95000) @(posedge core_clk);
      err_count++;
      stop_test();
   end
endmodule
`default_nettype wire
